// ===== core/fast_ethernet_pcs_codec.sv
`timescale 1ns/1ps
// Operation
// - take 3-bit link words only while link_tx_ready_o is high and forward them to the encoder
// - group link bits into 4-bit nibbles, one 5-bit symbol each
// - data nibbles map to the fixed sixteen-entry code table
// - idle code 11111 is sent between packets
// - start pair J then K replaces the first preamble byte
// - end pair is T then R
// - fields are not told apart; first byte becomes JK, rest table-coded
// - after the last data symbol send T R, then idle
// - each 5-bit symbol is scrambled before the line encoder
// - cipher key follows x[n] = x[n-11] xor x[n-9]
// - scrambled symbols leave as a 125 Mbps serial stream
// - a serial 0 keeps the line level
// - a serial 1 steps through negative, zero, positive, zero
// - receive: line decode, descramble, symbol decode, deliver nibbles
// - descrambler trains on the far sequence during idle
// - link loss during a frame is a receive error
// - incomplete JK after idle is a receive error
// - an invalid code inside a frame is a receive error
// - idle inside a frame before T R is a receive error
module fast_ethernet_pcs_codec
  import pcs_codec_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic link_clock_i,
  input wire logic [2:0] link_tx_data_i,
  input wire logic link_tx_en_i,
  output logic link_tx_ready_o,
  output logic [1:0] tx_level_o,
  output logic tx_bit_o,
  output logic tx_bit_strobe_o,
  input wire logic [1:0] rx_level_i,
  input wire logic rx_bit_toggle_i,
  input wire logic rx_link_ok_i,
  output logic [3:0] rx_nibble_o,
  output logic rx_nibble_valid_o,
  output logic rx_error_o,
  output logic rx_frame_o,
  output logic rx_lock_o
);
  // ----------------------------------------
  // reset release, one copy per domain
  // ----------------------------------------
  logic [1:0] rst_core_ff;
  logic [1:0] rst_link_ff;
  logic rst_core_b;
  logic rst_link_b;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_core_ff <= 2'h0;
    end else begin
      rst_core_ff <= {rst_core_ff[0], 1'b1};
    end
  end
  always_ff @(posedge link_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_link_ff <= 2'h0;
    end else begin
      rst_link_ff <= {rst_link_ff[0], 1'b1};
    end
  end
  assign rst_core_b = rst_core_ff[1];
  assign rst_link_b = rst_link_ff[1];

  // ----------------------------------------
  // link side: bit gathering and word handoff
  // ----------------------------------------
  core_st_s c_ff;
  link_st_s l_ff;
  link_st_s nxt_l;
  logic l_busy;
  logic l_accept;
  // two slots, each held until the core returns its toggle; one round trip outlasts a symbol
  always_comb begin
    logic [2:0] cnt;
    cnt = 3'h0;
    nxt_l = l_ff;
    nxt_l.ak1 = c_ff.ack;
    nxt_l.ak2 = l_ff.ak1;
    l_busy = l_ff.req[l_ff.wp] != l_ff.ak2[l_ff.wp];
    link_tx_ready_o = (l_ff.cnt <= 3'h3) && !l_ff.end_pend;
    l_accept = link_tx_en_i && link_tx_ready_o;
    cnt = l_ff.cnt;
    if (!l_busy) begin
      if (cnt >= 3'h4) begin
        nxt_l.word[l_ff.wp].nibble = 4'(l_ff.acc >> (cnt - 3'h4));
        nxt_l.word[l_ff.wp].first = l_ff.first_pend;
        nxt_l.word[l_ff.wp].endmark = 1'b0;
        nxt_l.req[l_ff.wp] = ~l_ff.req[l_ff.wp];
        nxt_l.first_pend = 1'b0;
        cnt = cnt - 3'h4;
      end else if (l_ff.end_pend) begin
        // leftover bits short of a nibble are dropped at frame end
        nxt_l.word[l_ff.wp] = '{nibble: 4'h0, first: 1'b0, endmark: 1'b1};
        nxt_l.req[l_ff.wp] = ~l_ff.req[l_ff.wp];
        nxt_l.end_pend = 1'b0;
        cnt = 3'h0;
      end
    end
    nxt_l.wp = l_ff.wp ^ (nxt_l.req != l_ff.req);
    if (l_accept) begin
      nxt_l.in_frame = 1'b1;
      if (!l_ff.in_frame) begin
        nxt_l.acc = {3'h0, link_tx_data_i};
        nxt_l.first_pend = 1'b1;
        cnt = 3'(LINK_W);
      end else begin
        nxt_l.acc = {l_ff.acc[2:0], link_tx_data_i};
        cnt = cnt + 3'(LINK_W);
      end
    end else if (!link_tx_en_i && l_ff.in_frame) begin
      nxt_l.in_frame = 1'b0;
      nxt_l.end_pend = 1'b1;
    end
    nxt_l.cnt = cnt;
  end
  // link state register
  always_ff @(posedge link_clock_i or negedge rst_link_b) begin
    if (!rst_link_b) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end
  a_word_hold: assert property (@(posedge link_clock_i) disable iff (!rst_link_b)
    l_busy |=> $stable(l_ff.word))
    else $error("handoff word changed while pending");

  // ----------------------------------------
  // core: transmit framing, scrambler, line coder, receive
  // ----------------------------------------
  core_st_s nxt_c;
  logic pend;
  logic strobe;
  logic load;
  logic take;
  logic [4:0] sym;
  logic scr_bit;
  logic rx_ev;
  logic sym_done;
  logic [4:0] nwin;
  dec_s dec;
  link_word_s word;
  always_comb begin
    logic [8:0] acc_sum;
    tx_state_e nxt_tx;
    logic raw;
    logic key;
    logic rbit;
    logic rkey;
    logic plain;
    acc_sum = 9'h0;
    nxt_tx = TX_IDLE;
    raw = 1'b0;
    key = 1'b0;
    rbit = 1'b0;
    rkey = 1'b0;
    plain = 1'b0;
    nwin = 5'h0;
    nxt_c = c_ff;
    nxt_c.rq1 = l_ff.req;
    nxt_c.rq2 = c_ff.rq1;
    pend = c_ff.rq2[c_ff.rp] != c_ff.ack[c_ff.rp];
    word = l_ff.word[c_ff.rp];
    // fractional rate: 5 bit strobes in every 8 cycles
    acc_sum = {1'b0, c_ff.acc} + ACC_STEP;
    strobe = acc_sum >= ACC_MOD;
    nxt_c.acc = strobe ? 8'(acc_sum - ACC_MOD) : acc_sum[7:0];
    load = strobe && (c_ff.bitcnt == 3'h0);
    take = 1'b0;
    sym = SYM_IDLE;
    // symbol choice; an underrun inside a frame closes it with T R
    case (c_ff.tx_state)
      TX_IDLE: begin
        if (pend && word.first && !word.endmark) begin
          sym = SYM_J;
          take = 1'b1;
          nxt_tx = TX_K;
        end else begin
          sym = SYM_IDLE;
          take = pend;
          nxt_tx = TX_IDLE;
        end
      end
      TX_K: begin
        sym = SYM_K;
        take = pend && !word.endmark && !word.first;
        nxt_tx = TX_DATA;
      end
      TX_DATA: begin
        if (pend && !word.endmark && !word.first) begin
          sym = enc_nibble(word.nibble);
          take = 1'b1;
          nxt_tx = TX_DATA;
        end else begin
          sym = SYM_T;
          take = pend && word.endmark;
          nxt_tx = TX_R;
        end
      end
      TX_R: begin
        sym = SYM_R;
        nxt_tx = TX_IDLE;
      end
      default: begin
        sym = SYM_IDLE;
        nxt_tx = TX_IDLE;
      end
    endcase
    if (load) begin
      nxt_c.tx_state = nxt_tx;
      nxt_c.last_sym = sym;
      if (take) begin
        nxt_c.ack[c_ff.rp] = ~c_ff.ack[c_ff.rp];
        nxt_c.rp = ~c_ff.rp;
      end
    end
    // serializer, msb of each symbol first
    raw = load ? sym[4] : c_ff.sh[4];
    key = c_ff.lfsr[TAP_OLD] ^ c_ff.lfsr[TAP_MID];
    scr_bit = raw ^ key;
    nxt_c.tx_strobe = strobe;
    if (strobe) begin
      nxt_c.sh = load ? {sym[3:0], 1'b0} : {c_ff.sh[3:0], 1'b0};
      nxt_c.bitcnt = load ? 3'(SYM_W - 1) : c_ff.bitcnt - 3'h1;
      nxt_c.lfsr = {c_ff.lfsr[9:0], key};
      nxt_c.tx_bit = scr_bit;
      if (scr_bit) begin
        nxt_c.phase = c_ff.phase + 2'h1;
      end
      nxt_c.tx_level = mlt_level(nxt_c.phase);
    end
    // receive pins: two flops each, three on the toggle; level must settle before the toggle edge
    nxt_c.lv1 = rx_level_i;
    nxt_c.lv2 = c_ff.lv1;
    nxt_c.tg1 = rx_bit_toggle_i;
    nxt_c.tg2 = c_ff.tg1;
    nxt_c.tg3 = c_ff.tg2;
    nxt_c.ok1 = rx_link_ok_i;
    nxt_c.ok2 = c_ff.ok1;
    rx_ev = c_ff.tg2 ^ c_ff.tg3;
    nxt_c.nib_vld = 1'b0;
    nxt_c.err = 1'b0;
    sym_done = 1'b0;
    if (c_ff.pre2) begin
      nxt_c.nib = PREAMBLE_NIB;
      nxt_c.nib_vld = 1'b1;
      nxt_c.pre2 = 1'b0;
    end
    rbit = c_ff.lv2 != c_ff.prev_lvl;
    rkey = c_ff.dsr[TAP_OLD] ^ c_ff.dsr[TAP_MID];
    plain = c_ff.lock ? (rbit ^ rkey) : 1'b1;
    nwin = {c_ff.win[3:0], plain};
    dec = dec_symbol(nwin);
    if (rx_ev) begin
      nxt_c.prev_lvl = c_ff.lv2;
      if (!c_ff.lock) begin
        // idle is all ones in clear, so each line bit reveals one key bit
        nxt_c.dsr = {c_ff.dsr[9:0], ~rbit};
        nxt_c.lockcnt = c_ff.lockcnt + 4'h1;
        nxt_c.lock = c_ff.lockcnt == 4'(LFSR_W - 1);
      end else begin
        nxt_c.dsr = {c_ff.dsr[9:0], rkey};
        nxt_c.win = nwin;
        nxt_c.rxcnt = c_ff.rxcnt + 3'h1;
        sym_done = c_ff.rxcnt == 3'(SYM_W - 1);
        if (sym_done) begin
          nxt_c.rxcnt = 3'h0;
        end
        case (c_ff.rx_state)
          RX_IDLE: begin
            if (nwin == SYM_J) begin
              nxt_c.rx_state = RX_K;
              nxt_c.rxcnt = 3'h0;
            end
          end
          RX_K: begin
            if (sym_done) begin
              if (nwin == SYM_K) begin
                nxt_c.rx_state = RX_FRAME;
                nxt_c.frame = 1'b1;
                nxt_c.nib = PREAMBLE_NIB;
                nxt_c.nib_vld = 1'b1;
                nxt_c.pre2 = 1'b1;
              end else begin
                nxt_c.rx_state = RX_IDLE;
                nxt_c.err = 1'b1;
              end
            end
          end
          RX_FRAME: begin
            if (sym_done) begin
              if (dec.is_data) begin
                nxt_c.nib = dec.nibble;
                nxt_c.nib_vld = 1'b1;
              end else if (nwin == SYM_T) begin
                nxt_c.rx_state = RX_R;
              end else if (nwin == SYM_IDLE) begin
                nxt_c.rx_state = RX_IDLE;
                nxt_c.frame = 1'b0;
                nxt_c.err = 1'b1;
              end else begin
                nxt_c.err = 1'b1;
              end
            end
          end
          RX_R: begin
            if (sym_done) begin
              nxt_c.rx_state = RX_IDLE;
              nxt_c.frame = 1'b0;
              nxt_c.err = nwin != SYM_R;
            end
          end
          default: begin
            nxt_c.rx_state = RX_IDLE;
          end
        endcase
      end
    end
    // link loss drops lock and any frame in progress
    if (!c_ff.ok2) begin
      nxt_c.lock = 1'b0;
      nxt_c.lockcnt = 4'h0;
      nxt_c.rx_state = RX_IDLE;
      nxt_c.frame = 1'b0;
      nxt_c.pre2 = 1'b0;
      nxt_c.err = c_ff.frame;
    end
  end
  // core state register; scrambler seed is nonzero
  always_ff @(posedge clock_i or negedge rst_core_b) begin
    if (!rst_core_b) begin
      c_ff <= '0;
      c_ff.lfsr <= LFSR_SEED;
      c_ff.phase <= 2'h1;
      c_ff.last_sym <= SYM_IDLE;
      c_ff.win <= SYM_IDLE;
    end else begin
      c_ff <= nxt_c;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign tx_level_o = c_ff.tx_level;
  assign tx_bit_o = c_ff.tx_bit;
  assign tx_bit_strobe_o = c_ff.tx_strobe;
  assign rx_nibble_o = c_ff.nib;
  assign rx_nibble_valid_o = c_ff.nib_vld;
  assign rx_error_o = c_ff.err;
  assign rx_frame_o = c_ff.frame;
  assign rx_lock_o = c_ff.lock;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_idle_fill: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (load && c_ff.tx_state == TX_IDLE && !(pend && word.first)) |-> sym == SYM_IDLE)
    else $error("non-idle symbol between packets");
  a_start_pair: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (load && c_ff.last_sym == SYM_J) |-> sym == SYM_K)
    else $error("J not followed by K");
  a_end_pair: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (load && c_ff.last_sym == SYM_T) |-> sym == SYM_R)
    else $error("T not followed by R");
  a_after_end: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (load && c_ff.last_sym == SYM_R) |-> (sym == SYM_IDLE || sym == SYM_J))
    else $error("bad symbol after R");
  a_sym_spacing: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    load |=> (!load)[*5])
    else $error("symbols loaded too close");
  a_mlt_hold: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (strobe && !scr_bit) |=> $stable(tx_level_o))
    else $error("line level moved on a zero");
  a_mlt_step: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (strobe && scr_bit) |=> tx_level_o == mlt_level(2'($past(c_ff.phase) + 2'h1)))
    else $error("line level missed its step");
  a_lfsr_live: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    c_ff.lfsr != 11'h000)
    else $error("scrambler locked at zero");
  a_bad_symbol: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (rx_ev && c_ff.lock && c_ff.ok2 && sym_done && c_ff.rx_state == RX_FRAME
     && !dec.is_data && nwin != SYM_T) |=> rx_error_o)
    else $error("invalid code not flagged");
  a_link_loss: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    (rx_frame_o && !c_ff.ok2) |=> (rx_error_o && !rx_frame_o))
    else $error("link loss in frame not flagged");
  a_lock_idle: assert property (@(posedge clock_i) disable iff (!rst_core_b)
    $rose(rx_lock_o) |-> $past(c_ff.rx_state) == RX_IDLE)
    else $error("descrambler locked outside idle");
endmodule // fast_ethernet_pcs_codec

// ===== core/pcs_codec_pkg.sv
package pcs_codec_pkg;
  // ----------------------------------------
  // rates and widths
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int LINE_MBPS = 125;
  localparam int LINK_W = 3;
  localparam int NIB_W = 4;
  localparam int SYM_W = 5;
  localparam int LFSR_W = 11;
  localparam int TAP_OLD = 10;
  localparam int TAP_MID = 8;
  localparam logic [8:0] ACC_STEP = 9'(LINE_MBPS);
  localparam logic [8:0] ACC_MOD = 9'(CLK_MHZ);
  localparam logic [10:0] LFSR_SEED = 11'h7FF;
  // ----------------------------------------
  // code groups and levels
  // ----------------------------------------
  localparam logic [4:0] SYM_IDLE = 5'h1F;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;
  localparam logic [1:0] MLT_ZERO = 2'h0;
  localparam logic [1:0] MLT_POS = 2'h1;
  localparam logic [1:0] MLT_NEG = 2'h3;
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_K, RX_FRAME, RX_R} rx_state_e;
  typedef struct packed {logic [3:0] nibble; logic first; logic endmark;} link_word_s;
  typedef struct packed {logic [3:0] nibble; logic is_data;} dec_s;
  typedef struct packed {
    logic [5:0] acc; logic [2:0] cnt; logic in_frame; logic first_pend;
    logic end_pend; link_word_s [1:0] word; logic [1:0] req; logic [1:0] ak1;
    logic [1:0] ak2; logic wp;
  } link_st_s;
  typedef struct packed {
    logic [1:0] rq1; logic [1:0] rq2; logic [1:0] ack; logic rp; tx_state_e tx_state;
    logic [4:0] sh;
    logic [2:0] bitcnt; logic [7:0] acc; logic [10:0] lfsr; logic [1:0] phase;
    logic [1:0] tx_level; logic tx_bit; logic tx_strobe; logic [4:0] last_sym;
    logic [1:0] lv1; logic [1:0] lv2; logic tg1; logic tg2; logic tg3;
    logic ok1; logic ok2; logic [1:0] prev_lvl; logic [10:0] dsr; logic lock;
    logic [3:0] lockcnt; logic [4:0] win; logic [2:0] rxcnt; rx_state_e rx_state;
    logic [3:0] nib; logic nib_vld; logic pre2; logic err; logic frame;
  } core_st_s;
  // ----------------------------------------
  // code tables
  // ----------------------------------------
  function automatic logic [4:0] enc_nibble(input logic [3:0] n);
    case (n)
      4'h0: return 5'h1E; 4'h1: return 5'h09; 4'h2: return 5'h14; 4'h3: return 5'h15;
      4'h4: return 5'h0A; 4'h5: return 5'h0B; 4'h6: return 5'h0E; 4'h7: return 5'h0F;
      4'h8: return 5'h12; 4'h9: return 5'h13; 4'hA: return 5'h16; 4'hB: return 5'h17;
      4'hC: return 5'h1A; 4'hD: return 5'h1B; 4'hE: return 5'h1C; default: return 5'h1D;
    endcase
  endfunction
  function automatic dec_s dec_symbol(input logic [4:0] s);
    dec_s d;
    d.is_data = 1'b0;
    d.nibble = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (enc_nibble(4'(i)) == s) begin
        d.is_data = 1'b1;
        d.nibble = 4'(i);
      end
    end
    return d;
  endfunction
  function automatic logic [1:0] mlt_level(input logic [1:0] ph);
    case (ph)
      2'h0: return MLT_NEG;
      2'h2: return MLT_POS;
      default: return MLT_ZERO;
    endcase
  endfunction
endpackage

// ===== dv/link_mac_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// controller side of the three-bit transmit link
// ----------------------------------------
module link_mac_model (
  input wire logic link_clock_i,
  input wire logic link_tx_ready_i,
  output logic [2:0] link_tx_data_o,
  output logic link_tx_en_o
);
  logic rdy_seen;

  initial begin
    link_tx_data_o = 3'h0;
    link_tx_en_o = 1'b0;
  end

  // ready moves just after the rising edge, so read it half a period later
  always @(negedge link_clock_i) begin
    rdy_seen = link_tx_ready_i;
  end

  // one frame, msb-first words, each held until the edge that takes it
  task automatic send(input logic [71:0] frame, input int words, output logic ok);
    int k;
    int guard;
    k = 1;
    guard = 0;
    ok = 1'b1;
    @(posedge link_clock_i);
    link_tx_en_o <= 1'b1;
    link_tx_data_o <= frame[71 -: 3];
    while (k <= words && guard < 2000) begin
      @(posedge link_clock_i);
      guard++;
      if (rdy_seen === 1'b1) begin
        if (k == words) begin
          // released lines must not keep showing the last word
          link_tx_en_o <= 1'b0;
          link_tx_data_o <= ~link_tx_data_o;
        end else begin
          link_tx_data_o <= frame[71 - 3 * k -: 3];
        end
        k++;
      end
    end
    if (k <= words) begin
      ok = 1'b0;
    end
  endtask
endmodule // link_mac_model

// ===== dv/tb_fast_ethernet_pcs_codec.sv
`timescale 1ns/1ps
module tb_fast_ethernet_pcs_codec;
  import pcs_codec_pkg::*;
  localparam int NBITS = 400;
  localparam logic [71:0] FRAME = 72'h55_0123_4567_89AB_CDEF;
  localparam logic [4:0] CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] ltx_data;
  logic ltx_en;
  logic ltx_ready;
  logic [1:0] tx_level;
  logic tx_bit;
  logic tx_strobe;
  logic [1:0] rx_lvl = 2'h0;
  logic rx_tog = 1'b0;
  logic rx_ok = 1'b0;
  logic [3:0] rx_nib;
  logic rx_vld;
  logic rx_err_p;
  logic rx_frame;
  logic rx_lock;
  int miscompares = 0;
  int checks_done = 0;
  logic cap_on = 1'b0;
  int ncap = 0;
  logic capb [NBITS];
  logic keyb [NBITS];
  logic plain [NBITS];
  int jpos = -1;
  logic [3:0] tx_st = {MLT_ZERO, MLT_NEG};
  logic [3:0] rx_st = {MLT_ZERO, MLT_NEG};
  logic [3:0] rx_q [$];
  int rx_errs = 0;
  logic frame_seen = 1'b0;
  logic ok;

  // ----------------------------------------
  // clocks, parts and shared helpers
  // ----------------------------------------
  always #2.5 clk = ~clk;
  // odd offset keeps link edges off core edges
  initial begin
    #1.1;
    forever #7.5 lclk = ~lclk;
  end

  fast_ethernet_pcs_codec uut (.clock_i(clk), .rst_b_i(rst_b), .link_clock_i(lclk),
    .link_tx_data_i(ltx_data), .link_tx_en_i(ltx_en), .link_tx_ready_o(ltx_ready),
    .tx_level_o(tx_level), .tx_bit_o(tx_bit), .tx_bit_strobe_o(tx_strobe),
    .rx_level_i(rx_lvl), .rx_bit_toggle_i(rx_tog), .rx_link_ok_i(rx_ok),
    .rx_nibble_o(rx_nib), .rx_nibble_valid_o(rx_vld), .rx_error_o(rx_err_p),
    .rx_frame_o(rx_frame), .rx_lock_o(rx_lock));
  link_mac_model mac (.link_clock_i(lclk), .link_tx_ready_i(ltx_ready),
    .link_tx_data_o(ltx_data), .link_tx_en_o(ltx_en));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // {level, last nonzero level}; one step of the three-level line code
  function automatic logic [3:0] mlt_step(input logic [3:0] st);
    if (st[3:2] != MLT_ZERO) return {MLT_ZERO, st[3:2]};
    return {(st[1:0] == MLT_NEG) ? MLT_POS : MLT_NEG, st[1:0]};
  endfunction

  // outputs are registered on the rising edge, so look at them on the falling one
  always @(negedge clk) begin
    if (rst_b && tx_strobe === 1'b1) begin
      if (tx_bit === 1'b1) tx_st = mlt_step(tx_st);
      check(32'(tx_level), 32'(tx_st[3:2]));
      if (cap_on && ncap < NBITS) begin
        capb[ncap] = tx_bit;
        ncap++;
      end
    end
    if (rx_vld === 1'b1) rx_q.push_back(rx_nib);
    if (rx_err_p === 1'b1) rx_errs++;
    if (rx_frame === 1'b1) frame_seen = 1'b1;
  end

  task automatic wait_bits(input int n);
    int guard;
    guard = 0;
    while (ncap < n && guard < 5000) begin
      @(posedge clk);
      guard++;
    end
    if (ncap < n) begin
      miscompares++;
      results();
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // exactly 5 serial bits leave per 8 core cycles
  task automatic line_rate;
    int n;
    n = 0;
    repeat (80) begin
      @(negedge clk);
      if (tx_strobe === 1'b1) n++;
    end
    check(32'(n), 32'd50);
  endtask

  // capture a frame on the wire, strip the cipher ourselves and read the symbols
  task automatic tx_frame;
    logic [9:0] w;
    logic [4:0] sym;
    logic [4:0] exp;
    logic all_idle;
    cap_on = 1'b1;
    wait_bits(30);
    mac.send(FRAME, 24, ok);
    check(32'(ok), 32'd1);
    wait_bits(NBITS);
    // idle is all ones, so the first 11 bits give the key state
    for (int i = 0; i < NBITS; i++) begin
      keyb[i] = (i < 11) ? ~capb[i] : keyb[i - 11] ^ keyb[i - 9];
      plain[i] = capb[i] ^ keyb[i];
    end
    check(32'(keyb[0] | keyb[3] | keyb[7] | keyb[10]), 32'd1);
    for (int i = 11; i < NBITS - 120; i++) begin
      for (int t = 0; t < 10; t++) w = {w[8:0], plain[i + t]};
      if (jpos < 0 && w == {SYM_J, SYM_K}) jpos = i;
    end
    check(32'(jpos > 0), 32'd1);
    if (jpos < 0) results();
    all_idle = 1'b1;
    for (int i = 0; i < jpos; i++) all_idle &= plain[i];
    check(32'(all_idle), 32'd1);
    for (int s = 0; s < 20; s++) begin
      for (int t = 0; t < 5; t++) sym = {sym[3:0], plain[jpos + 10 + 5 * s + t]};
      exp = (s < 16) ? CODE[s] : (s == 16) ? 5'h0D : (s == 17) ? 5'h07 : 5'h1F;
      check(32'(sym), 32'(exp));
    end
  endtask

  // play the captured stream back into the receiver, optionally spoiled
  task automatic replay(input int mode);
    logic p;
    rx_ok <= 1'b0;
    repeat (10) @(posedge clk);
    rx_ok <= 1'b1;
    repeat (5) @(posedge clk);
    rx_q.delete();
    rx_errs = 0;
    frame_seen = 1'b0;
    for (int i = 0; i < NBITS; i++) begin
      p = plain[i];
      if (mode == 1 && i >= jpos + 20 && i < jpos + 25) p = 1'b0;
      if (mode == 2 && i >= jpos + 25 && i < jpos + 100) p = 1'b1;
      if (mode == 3 && i >= jpos + 5 && i < jpos + 10) p = CODE[5][jpos + 9 - i];
      if ((p ^ keyb[i]) == 1'b1) rx_st = mlt_step(rx_st);
      @(posedge clk);
      rx_lvl <= rx_st[3:2];
      if (mode == 4 && i == jpos + 50) rx_ok <= 1'b0;
      // level stands four cycles before the bit is announced
      repeat (4) @(posedge clk);
      rx_tog <= ~rx_tog;
    end
    repeat (20) @(posedge clk);
  endtask

  task automatic rx_clean;
    replay(0);
    check(32'(rx_q.size()), 32'd18);
    for (int k = 0; k < 18 && k < rx_q.size(); k++) begin
      check(32'(rx_q[k]), (k < 2) ? 32'h5 : 32'(k - 2));
    end
    check(32'(rx_errs), 32'd0);
    check(32'(frame_seen), 32'd1);
    check(32'(rx_frame), 32'd0);
    check(32'(rx_lock), 32'd1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    // reset clears both domains at once; each copy lets go two of its own edges later
    repeat (2) @(posedge clk);
    check({27'h0, tx_level, tx_strobe, rx_frame, rx_lock}, 32'h0);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    line_rate();
    tx_frame();
    rx_clean();
    replay(1);
    check(32'(rx_errs != 0), 32'd1);
    replay(2);
    check(32'(rx_errs != 0), 32'd1);
    replay(3);
    check(32'(rx_errs != 0), 32'd1);
    replay(4);
    check(32'(rx_errs != 0), 32'd1);
    check(32'(rx_frame), 32'd0);
    results();
  end

  // cut a hung run short
  initial begin
    #300000;
    miscompares++;
    results();
  end
endmodule // tb_fast_ethernet_pcs_codec
